// *** pkg/omc_defines.vh ***
// operating mode control constants: layout, reset values, timing counts
`ifndef OMC_DEFINES_VH
`define OMC_DEFINES_VH
`define OMC_WIDTH 16
`define OMC_BIT_BOOT_LOW 0
`define OMC_BIT_BOOT_HIGH 1
`define OMC_BIT_MASTER 2
`define OMC_BIT_ROUND 4
`define OMC_BIT_CLAMP 5
`define OMC_BIT_STOP_DELAY 6
`define OMC_BIT_CLK_DIS 7
`define OMC_WRITE_MASK 16'h00F7
`define OMC_SOFT_RESET 16'h0000
`define OMC_ACC_WIDTH 40
`define OMC_CLAMP_POS 40'h007FFFFFFF
`define OMC_CLAMP_NEG 40'hFF80000000
`define OMC_ROUND_HALF 40'h0000008000
`define OMC_ROUND_KEEP 40'hFFFFFF0000
`define OMC_LOW_MASK 40'h000000FFFF
`define OMC_SP_WIDTH 6
`define OMC_SP_EMPTY 6'h00
`define OMC_SP_FULL 6'h0F
`define OMC_SP_BIT_UF 5
`define OMC_SP_BIT_SE 4
`define OMC_WAKE_SHORT_CYCLES 12'h010
`define OMC_WAKE_LONG_CYCLES 12'h800
`define OMC_WAKE_CNT_WIDTH 12
`endif

// *** src/omc_operating_mode_control.v ***
// operating mode register with its mode-dependent datapath and pin logic
//
// Function
// - 16-bit mode register changes only at reset or by instruction write.
// - Boot and bus mode bits are captured from mode-select pins at reset.
// - Master mode drives bus request, takes grant; slave mode the reverse.
// - Clamp enable saturates multiplier results whose bits 39, 32, 31 differ to signed 32-bit range.
// - Clamp decision looks only at extension bits 7, 0 and msp bit 15.
// - Equal bits keep result; else 00 7FFF FFFF or FF 8000 0000 by bit 7.
// - Round select set always rounds a half up; clear uses convergent rounding.
// - Stop delay bit chooses between two wake delays leaving stop.
// - Clock output runs while disable is clear; stops one instruction later.
// - Instruction-written bits take effect after one further instruction cycle.
// - Reserved bits read zero; software writes zero to them.
// - RAM variant: boot modes select bootstrap, internal RAM and reset vector.
// - ROM variant: boot modes select internal ROM and reset vector.
// - Stack pointer resets empty; encodes full, overflow and underflow states.
`timescale 1ns/100ps
`default_nettype none
`include "omc_defines.vh"

module omc_operating_mode_control (
    // clock, reset, enable
    input wire sys_clk,
    input wire rst_n,
    input wire clk_en,
    // mode-select pins
    input wire boot_mode_low,
    input wire boot_mode_high,
    input wire bus_master_select,
    // instruction access to the register
    input wire instr_cycle,
    input wire omc_wr_en,
    input wire [15:0] omc_wr_data,
    output reg [15:0] operating_mode_control,
    output reg [15:0] omc_effective,
    // bus arbitration: request and grant pins active low, enables and core side active high
    input wire bus_request_n_in,
    output reg bus_request_n_out,
    output reg bus_request_oe,
    input wire bus_grant_n_in,
    output reg bus_grant_n_out,
    output reg bus_grant_oe,
    input wire core_bus_need,
    output reg core_bus_owned,
    // accumulator write-back
    input wire mac_valid,
    input wire [39:0] mac_result,
    input wire round_req,
    output reg acc_valid,
    output reg [39:0] acc_result,
    // stop mode
    input wire stop_req,
    input wire wake_event,
    output reg core_stopped,
    // clock output
    output reg clock_output_pin,
    // boot decode
    input wire rom_variant,
    output reg boot_from_memory,
    output reg boot_from_host,
    output reg internal_mem_enable,
    output reg [15:0] reset_vector,
    // stack pointer
    input wire stack_push,
    input wire stack_pull,
    output reg [5:0] stack_pointer,
    output reg stack_underflow_flag,
    output reg stack_empty_flag
);

    // pins come from outside: three stages, change counts when 2 and 3 agree
    reg [2:0] pin_s1, pin_s2, pin_s3;
    reg [1:0] arb_s1, arb_s2, arb_s3;
    reg [1:0] arb_ok;
    reg strap_pending;
    reg commit_pending;
    reg stopping;
    reg [11:0] wake_cnt;
    reg clk_div;
    reg [39:0] next_acc;
    wire [5:0] next_sp_push = stack_pointer + 6'h01;
    wire [5:0] next_sp_pull = stack_pointer - 6'h01;

    function [39:0] omc_clamp;
        input [39:0] val;
        begin
            if (val[39] == val[32] && val[32] == val[31])
                omc_clamp = val;
            else if (val[39] == 1'b0)
                omc_clamp = `OMC_CLAMP_POS;
            else
                omc_clamp = `OMC_CLAMP_NEG;
        end
    endfunction

    // convergent rounding skips increment on exact half with even lsb
    function [39:0] omc_round;
        input [39:0] val;
        input twos;
        reg [39:0] sum;
        begin
            sum = val + `OMC_ROUND_HALF;
            if (!twos && (val & `OMC_LOW_MASK) == `OMC_ROUND_HALF && !val[16])
                omc_round = val & `OMC_ROUND_KEEP;
            else
                omc_round = sum & `OMC_ROUND_KEEP;
        end
    endfunction

    // synchroniser stages carry no reset so they sample during reset
    always @(posedge sys_clk) begin
        if (clk_en) begin
            pin_s1 <= {bus_master_select, boot_mode_high, boot_mode_low};
            pin_s2 <= pin_s1;
            pin_s3 <= pin_s2;
            arb_s1 <= {bus_grant_n_in, bus_request_n_in};
            arb_s2 <= arb_s1;
            arb_s3 <= arb_s2;
        end
    end

    // agreed values of stages two and three
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            arb_ok <= 2'h3;
        end else if (clk_en) begin
            if (arb_s2 == arb_s3)
                arb_ok <= arb_s3;
        end
    end

    // mode register: straps after release, instruction writes otherwise
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            operating_mode_control <= `OMC_SOFT_RESET;
            omc_effective <= `OMC_SOFT_RESET;
            strap_pending <= 1'b1;
            commit_pending <= 1'b0;
        end else if (clk_en) begin
            if (strap_pending && pin_s2 == pin_s3) begin
                // strap capture applies at once, nothing to delay
                operating_mode_control <= {13'h0, pin_s3};
                omc_effective <= {13'h0, pin_s3};
                strap_pending <= 1'b0;
            end else if (!strap_pending && omc_wr_en) begin
                operating_mode_control <= omc_wr_data & `OMC_WRITE_MASK;
                commit_pending <= 1'b1;
            end else if (commit_pending && instr_cycle) begin
                omc_effective <= operating_mode_control;
                commit_pending <= 1'b0;
            end
        end
    end

    // bus role pins; a mode change mid-tenure is software's hazard
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            bus_request_n_out <= 1'b1;
            bus_request_oe <= 1'b0;
            bus_grant_n_out <= 1'b1;
            bus_grant_oe <= 1'b0;
            core_bus_owned <= 1'b0;
        end else if (clk_en) begin
            if (omc_effective[`OMC_BIT_MASTER]) begin
                bus_request_oe <= 1'b1;
                bus_grant_oe <= 1'b0;
                bus_request_n_out <= !core_bus_need;
                bus_grant_n_out <= 1'b1;
                core_bus_owned <= core_bus_need && !arb_ok[1];
            end else begin
                bus_request_oe <= 1'b0;
                bus_grant_oe <= 1'b1;
                bus_request_n_out <= 1'b1;
                bus_grant_n_out <= !(!arb_ok[0] && !core_bus_need);
                core_bus_owned <= arb_ok[0];
            end
        end
    end

    // accumulator write-back path
    always @* begin
        next_acc = mac_result;
        if (round_req)
            next_acc = omc_round(next_acc, omc_effective[`OMC_BIT_ROUND]);
        if (omc_effective[`OMC_BIT_CLAMP])
            next_acc = omc_clamp(next_acc);
    end

    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            acc_valid <= 1'b0;
            acc_result <= 40'h0000000000;
        end else if (clk_en) begin
            acc_valid <= mac_valid;
            if (mac_valid)
                acc_result <= next_acc;
        end
    end

    // stop mode with selectable wake delay
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            core_stopped <= 1'b0;
            stopping <= 1'b0;
            wake_cnt <= 12'h000;
        end else if (clk_en) begin
            if (!core_stopped) begin
                core_stopped <= stop_req;
                stopping <= 1'b0;
            end else if (!stopping) begin
                if (wake_event) begin
                    stopping <= 1'b1;
                    wake_cnt <= omc_effective[`OMC_BIT_STOP_DELAY] ?
                        `OMC_WAKE_SHORT_CYCLES : `OMC_WAKE_LONG_CYCLES;
                end
            end else if (wake_cnt == 12'h001) begin
                core_stopped <= 1'b0;
                stopping <= 1'b0;
            end else begin
                wake_cnt <= wake_cnt - 12'h001;
            end
        end
    end

    // clock out at half rate; disable follows the effective copy
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            clk_div <= 1'b0;
            clock_output_pin <= 1'b0;
        end else if (clk_en) begin
            clk_div <= !clk_div;
            clock_output_pin <= omc_effective[`OMC_BIT_CLK_DIS] ? 1'b0 : clk_div;
        end
    end

    // boot decode from the two boot mode bits
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            boot_from_memory <= 1'b0;
            boot_from_host <= 1'b0;
            internal_mem_enable <= 1'b0;
            reset_vector <= 16'h0000;
        end else if (clk_en) begin
            case (omc_effective[1:0])
                2'h0: begin
                    boot_from_memory <= !rom_variant;
                    boot_from_host <= 1'b0;
                    internal_mem_enable <= 1'b1;
                    reset_vector <= rom_variant ? 16'h0000 : 16'hC000;
                end
                2'h1: begin
                    // reserved on the rom variant: no boot action
                    boot_from_memory <= 1'b0;
                    boot_from_host <= !rom_variant;
                    internal_mem_enable <= !rom_variant;
                    reset_vector <= 16'h0000;
                end
                2'h2: begin
                    boot_from_memory <= 1'b0;
                    boot_from_host <= 1'b0;
                    internal_mem_enable <= 1'b1;
                    reset_vector <= 16'hE000;
                end
                default: begin
                    boot_from_memory <= 1'b0;
                    boot_from_host <= 1'b0;
                    internal_mem_enable <= 1'b0;
                    reset_vector <= 16'h0000;
                end
            endcase
        end
    end

    // stack pointer as a 6-bit counter; flags ride in the top two bits
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            stack_pointer <= `OMC_SP_EMPTY;
            stack_underflow_flag <= 1'b0;
            stack_empty_flag <= 1'b0;
        end else if (clk_en) begin
            if (stack_push && !stack_pull) begin
                stack_pointer <= next_sp_push;
                stack_underflow_flag <= next_sp_push[`OMC_SP_BIT_UF];
                stack_empty_flag <= next_sp_push[`OMC_SP_BIT_SE];
            end else if (stack_pull && !stack_push) begin
                stack_pointer <= next_sp_pull;
                stack_underflow_flag <= next_sp_pull[`OMC_SP_BIT_UF];
                stack_empty_flag <= next_sp_pull[`OMC_SP_BIT_SE];
            end
        end
    end

endmodule // omc_operating_mode_control
`default_nettype wire

// *** tb/omc_checker.sv ***
// concurrent checks on the operating mode control ports
`timescale 1ns/100ps
`default_nettype none
`include "omc_defines.vh"
module omc_checker (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic clk_en,
    // register access
    input wire logic instr_cycle,
    input wire logic omc_wr_en,
    input wire logic [15:0] omc_wr_data,
    input wire logic [15:0] operating_mode_control,
    input wire logic [15:0] omc_effective,
    // accumulator path
    input wire logic mac_valid,
    input wire logic [39:0] mac_result,
    input wire logic round_req,
    input wire logic acc_valid,
    input wire logic [39:0] acc_result,
    // pins and stack
    input wire logic clock_output_pin,
    input wire logic stack_push,
    input wire logic stack_pull,
    input wire logic [5:0] stack_pointer
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    // straps load in the first edges, so writes are judged only later
    logic [2:0] up;
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n)
            up <= 3'h0;
        else if (up != 3'h7)
            up <= up + 3'h1;
    end
    wire logic take = clk_en && mac_valid && !round_req;
    wire logic same = (mac_result[39] == mac_result[32]) && (mac_result[32] == mac_result[31]);
    sequence s_commit; up == 3'h7 && clk_en && instr_cycle && !omc_wr_en; endsequence
    sequence s_off; (clk_en && omc_effective[7]) [*3]; endsequence
    sequence s_run; (clk_en && !omc_effective[7]) [*2]; endsequence
    property p_rsv; (operating_mode_control & 16'hFF08) == 16'h0000; endproperty
    a_rsv: assert property (p_rsv) else $error("reserved bit set");
    property p_wr; up == 3'h7 && clk_en && omc_wr_en |=> operating_mode_control == ($past(omc_wr_data) & `OMC_WRITE_MASK); endproperty
    a_wr: assert property (p_wr) else $error("write lost");
    property p_hold; up == 3'h7 && !(clk_en && omc_wr_en) |=> $stable(operating_mode_control); endproperty
    a_hold: assert property (p_hold) else $error("register moved");
    property p_commit; s_commit |=> omc_effective == $past(operating_mode_control); endproperty
    a_commit: assert property (p_commit) else $error("no commit");
    property p_eff; up == 3'h7 && !(clk_en && instr_cycle) |=> $stable(omc_effective); endproperty
    a_eff: assert property (p_eff) else $error("early effect");
    property p_keep; take && (!omc_effective[5] || same) |=> acc_valid && acc_result == $past(mac_result); endproperty
    a_keep: assert property (p_keep) else $error("result altered");
    property p_sat; take && omc_effective[5] && !same |=> acc_result == ($past(mac_result[39]) ? `OMC_CLAMP_NEG : `OMC_CLAMP_POS); endproperty
    a_sat: assert property (p_sat) else $error("bad clamp");
    property p_push; clk_en && stack_push && !stack_pull && stack_pointer < 6'h11 |=> stack_pointer == $past(stack_pointer) + 6'h01; endproperty
    a_push: assert property (p_push) else $error("bad push");
    property p_off; s_off |-> !clock_output_pin; endproperty
    a_off: assert property (p_off) else $error("clock not stopped");
    property p_run; s_run |=> clock_output_pin != $past(clock_output_pin); endproperty
    a_run: assert property (p_run) else $error("clock not running");
endmodule // omc_checker
bind omc_operating_mode_control omc_checker chk (
    .sys_clk(sys_clk), .rst_n(rst_n), .clk_en(clk_en), .instr_cycle(instr_cycle), .omc_wr_en(omc_wr_en),
    .omc_wr_data(omc_wr_data), .operating_mode_control(operating_mode_control), .omc_effective(omc_effective),
    .mac_valid(mac_valid), .mac_result(mac_result), .round_req(round_req), .acc_valid(acc_valid),
    .acc_result(acc_result), .clock_output_pin(clock_output_pin), .stack_push(stack_push),
    .stack_pull(stack_pull), .stack_pointer(stack_pointer));
`default_nettype wire

// *** tb/test_operating_mode_control.sv ***
// self-checking bench for the operating mode control block
`timescale 1ns/100ps
`default_nettype none
`include "omc_defines.vh"
module test_operating_mode_control;
    logic sys_clk = 1'h0, rst_n = 1'h0, clk_en = 1'h1, ml = 1'h0, mh = 1'h0, ms = 1'h0, rv = 1'h0;
    logic ic = 1'h0, we = 1'h0, mv = 1'h0, rr = 1'h0, sr = 1'h0, wk = 1'h0, pu = 1'h0, pl = 1'h0;
    logic [15:0] wd = 16'h0000;
    logic rin = 1'h1, gin = 1'h1, need = 1'h0;
    wire rq_n, gt_n, own;
    logic [39:0] mr = 40'h0000000000;
    wire [15:0] omc, eff, vec;
    wire [39:0] ares;
    wire [5:0] sp;
    wire av, stp, pin, bm, bh, ime, rq_oe, gt_oe, uf, se;
    int err_total = 0, samples_checked = 0;
    omc_operating_mode_control uut (.sys_clk(sys_clk), .rst_n(rst_n), .clk_en(clk_en),
        .boot_mode_low(ml), .boot_mode_high(mh), .bus_master_select(ms), .instr_cycle(ic),
        .omc_wr_en(we), .omc_wr_data(wd), .operating_mode_control(omc), .omc_effective(eff),
        .bus_request_n_in(rin), .bus_request_n_out(rq_n), .bus_request_oe(rq_oe), .bus_grant_n_in(gin),
        .bus_grant_n_out(gt_n), .bus_grant_oe(gt_oe), .core_bus_need(need), .core_bus_owned(own),
        .mac_valid(mv), .mac_result(mr), .round_req(rr), .acc_valid(av), .acc_result(ares),
        .stop_req(sr), .wake_event(wk), .core_stopped(stp), .clock_output_pin(pin),
        .rom_variant(rv), .boot_from_memory(bm), .boot_from_host(bh), .internal_mem_enable(ime),
        .reset_vector(vec), .stack_push(pu), .stack_pull(pl), .stack_pointer(sp),
        .stack_underflow_flag(uf), .stack_empty_flag(se));
    always #4 sys_clk = ~sys_clk;
    task automatic chk(input string n, input logic [40:0] s, input logic [40:0] e);
        samples_checked++;
        if (s !== e) begin
            err_total++;
            $display("BAD %s exp %h seen %h", n, e, s);
        end
    endtask
    // pins stay put through reset and well past release
    task automatic rst(input logic [2:0] p);
        rst_n <= 1'h0;
        {ms, mh, ml} <= p;
        repeat (10) @(posedge sys_clk);
        rst_n <= 1'h1;
        repeat (6) @(posedge sys_clk);
    endtask
    task automatic wr(input logic [15:0] d);
        logic [15:0] o;
        o = eff;
        we <= 1'h1;
        wd <= d;
        @(posedge sys_clk);
        we <= 1'h0;
        @(negedge sys_clk);
        chk("reg", omc, d & `OMC_WRITE_MASK);
        chk("held", eff, o);
        @(posedge sys_clk);
        ic <= 1'h1;
        @(posedge sys_clk);
        ic <= 1'h0;
        repeat (2) @(posedge sys_clk);
        @(negedge sys_clk);
        chk("eff", eff, d & `OMC_WRITE_MASK);
        @(posedge sys_clk);
    endtask
    task automatic mac(input logic [39:0] r, input logic rnd, input logic [39:0] e);
        mv <= 1'h1;
        mr <= r;
        rr <= rnd;
        @(posedge sys_clk);
        mv <= 1'h0;
        @(negedge sys_clk);
        chk("acc", {av, ares}, {1'h1, e});
        @(posedge sys_clk);
    endtask
    task automatic t_strap;
        logic [11:0] fl;
        for (int v = 0; v < 2; v++) begin
            for (int i = 0; i < 4; i++) begin
                rv <= v[0];
                rst({1'h0, i[1:0]});
                fl = v ? 12'h041 : 12'h05D;
                chk("strap", omc[2:0], i[2:0]);
                chk("slave", {rq_oe, gt_oe}, 2'h1);
                chk("boot", {bm, bh, ime}, fl[i*3+:3]);
                if (i != 1)
                    chk("vector", vec, i == 2 ? 16'hE000 : (i == 0 && v == 0) ? 16'hC000 : 16'h0000);
            end
        end
        rv <= 1'h0;
        $display("strap test done");
    endtask
    task automatic t_mode;
        logic p;
        rst(3'h4);
        chk("master", {rq_oe, gt_oe}, 2'h2);
        need <= 1'h1;
        gin <= 1'h0;
        repeat (6) @(posedge sys_clk);
        chk("owned", {rq_n, own}, 2'h1);
        need <= 1'h0;
        gin <= 1'h1;
        @(negedge sys_clk);
        p = pin;
        @(negedge sys_clk);
        chk("clk run", pin, !p);
        @(posedge sys_clk);
        wr(16'hFFFF);
        repeat (3) @(negedge sys_clk);
        chk("clk off", pin, 1'h0);
        @(posedge sys_clk);
        $display("mode test done");
    endtask
    task automatic t_mac;
        logic [39:0] r;
        for (int k = 0; k < 8; k++) begin
            r = {k[2], 6'h00, k[1], k[0], 31'h00001234};
            mac(r, 1'h0, (k == 0 || k == 7) ? r : k[2] ? `OMC_CLAMP_NEG : `OMC_CLAMP_POS);
        end
        mac(40'h0000028000, 1'h1, 40'h0000030000);
        wr(16'h0020);
        @(negedge sys_clk);
        chk("slave", {rq_oe, gt_oe}, 2'h1);
        chk("idle", {gt_n, own}, 2'h3);
        @(posedge sys_clk);
        rin <= 1'h0;
        repeat (6) @(posedge sys_clk);
        chk("grant", {gt_n, own}, 2'h0);
        rin <= 1'h1;
        mac(40'h0000028000, 1'h1, 40'h0000020000);
        mac(40'h0000018000, 1'h1, 40'h0000020000);
        wr(16'h0000);
        mac(40'h0080000000, 1'h0, 40'h0080000000);
        $display("mac test done");
    endtask
    // long wake is run once only, it costs two thousand cycles
    task automatic t_stop;
        for (int s = 1; s >= 0; s--) begin
            wr(s ? 16'h0040 : 16'h0000);
            sr <= 1'h1;
            @(posedge sys_clk);
            sr <= 1'h0;
            wk <= 1'h1;
            @(posedge sys_clk);
            wk <= 1'h0;
            repeat (12) @(posedge sys_clk);
            chk("stop", stp, 1'h1);
            repeat (s ? 8 : 2040) @(posedge sys_clk);
            chk("wake", stp, 1'h0);
        end
        $display("stop test done");
    endtask
    task automatic t_stack;
        rst(3'h0);
        chk("sp rst", sp, 6'h00);
        {pu, pl} <= 2'h2;
        repeat (15) @(posedge sys_clk);
        {pu, pl} <= 2'h0;
        @(negedge sys_clk);
        chk("sp full", sp, 6'h0F);
        @(posedge sys_clk);
        {pu, pl} <= 2'h2;
        @(posedge sys_clk);
        {pu, pl} <= 2'h0;
        @(negedge sys_clk);
        chk("sp ovf", {uf, se, sp}, {2'h1, 6'h10});
        @(posedge sys_clk);
        {pu, pl} <= 2'h2;
        @(posedge sys_clk);
        {pu, pl} <= 2'h3;
        @(posedge sys_clk);
        {pu, pl} <= 2'h0;
        @(negedge sys_clk);
        chk("sp ovf2", {uf, se, sp}, {2'h1, 6'h11});
        @(posedge sys_clk);
        rst(3'h0);
        {pu, pl} <= 2'h1;
        @(posedge sys_clk);
        {pu, pl} <= 2'h0;
        @(negedge sys_clk);
        chk("sp unf", {uf, se, sp}, {2'h3, 6'h3F});
        @(posedge sys_clk);
        {pu, pl} <= 2'h1;
        @(posedge sys_clk);
        {pu, pl} <= 2'h0;
        @(negedge sys_clk);
        chk("sp unf2", {uf, se, sp}, {2'h3, 6'h3E});
        $display("stack test done");
    endtask
    task automatic final_report;
        $display("checks %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    initial begin
        t_strap;
        t_mode;
        t_mac;
        t_stop;
        t_stack;
        final_report;
    end
    initial begin
        #100000;
        err_total++;
        final_report;
    end
endmodule // test_operating_mode_control
`default_nettype wire
